/* table_search_op.sv */
// Table search instruction sequencer over a character-addressed memory
`timescale 1ns/1ps
module table_search_op (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [table_search_pkg::FMT_W-1:0] format,
  input wire logic [table_search_pkg::ADDR_W-1:0] a_addr,
  input wire logic [table_search_pkg::ADDR_W-1:0] b_addr,
  input wire logic [table_search_pkg::VAR_W-1:0] variant_in,
  output logic busy,
  output logic done,
  output logic mem_req,
  output logic [table_search_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [table_search_pkg::CHAR_W-1:0] mem_rdata,
  input wire logic mem_rwm,
  output logic cmp_low,
  output logic cmp_equal,
  output logic cmp_high,
  output logic [table_search_pkg::ADDR_W-1:0] first_operand_pointer,
  output logic [table_search_pkg::ADDR_W-1:0] second_operand_pointer,
  output logic [table_search_pkg::VAR_W-1:0] variant_held
);

  // ************************************************************
  // Types and helpers
  // ************************************************************
  // Gray order along the usual path: idle, argument, table, skip
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARG = 2'h1,
    ST_TAB = 2'h3,
    ST_SKIP = 2'h2
  } state_e;

  // Pointers step down modulo the address width; a table may wrap past zero
  function automatic logic [table_search_pkg::ADDR_W-1:0] dec(input logic [table_search_pkg::ADDR_W-1:0] a);
    dec = a - table_search_pkg::ADDR_ONE;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  state_e state_reg;
  state_e state_next;
  logic [table_search_pkg::VAR_W-1:0] variant_reg;
  logic [table_search_pkg::VAR_W-1:0] variant_next;
  logic [table_search_pkg::ADDR_W-1:0] first_ptr_reg;
  logic [table_search_pkg::ADDR_W-1:0] first_ptr_next;
  logic [table_search_pkg::ADDR_W-1:0] bar_reg;
  logic [table_search_pkg::ADDR_W-1:0] bar_next;
  logic [table_search_pkg::ADDR_W-1:0] arg_start_reg;
  logic [table_search_pkg::ADDR_W-1:0] arg_start_next;
  logic [table_search_pkg::ADDR_W-1:0] arg_ptr_reg;
  logic [table_search_pkg::ADDR_W-1:0] arg_ptr_next;
  logic [table_search_pkg::ADDR_W-1:0] tab_ptr_reg;
  logic [table_search_pkg::ADDR_W-1:0] tab_ptr_next;
  logic [table_search_pkg::ADDR_W-1:0] mem_addr_reg;
  logic [table_search_pkg::ADDR_W-1:0] mem_addr_next;
  logic [table_search_pkg::CHAR_W-1:0] arg_char_reg;
  logic [table_search_pkg::CHAR_W-1:0] arg_char_next;
  logic arg_wm_reg;
  logic arg_wm_next;
  logic low_reg;
  logic low_next;
  logic equal_reg;
  logic equal_next;
  logic high_reg;
  logic high_next;
  logic done_reg;
  logic done_next;

  logic cmp_clear;
  logic cmp_step;
  logic hit;
  logic [table_search_pkg::ADDR_W-1:0] a_sel;
  logic [table_search_pkg::ADDR_W-1:0] b_sel;
  logic start_taken;
  table_search_pkg::rel_e rel_now;

  // ************************************************************
  // Field comparison and relation decode
  // ************************************************************
  // Compare is judged on the table character while its ack stands
  char_compare u_compare (
    .clk(clk),
    .srst(srst),
    .clear(cmp_clear),
    .step(cmp_step),
    .stored(mem_rdata),
    .search(arg_char_reg),
    .rel_now(rel_now),
    .rel_reg()
  );

  relation_decode u_decode (
    .variant(variant_reg),
    .rel(rel_now),
    .hit(hit)
  );

  // ************************************************************
  // Operand selection per format
  // ************************************************************
  // Held registers stand in for omitted operands; only a taken start loads the variant, the pointers also load at done
  always_comb begin
    start_taken = start && (state_reg == ST_IDLE);
    a_sel = a_addr;
    b_sel = b_addr;
    variant_next = variant_reg;
    case (format)
      table_search_pkg::FMT_A: begin
        variant_next = variant_in;
      end
      table_search_pkg::FMT_B: begin
        variant_next = variant_reg;
      end
      table_search_pkg::FMT_C: begin
        b_sel = bar_reg;
      end
      table_search_pkg::FMT_D: begin
        a_sel = first_ptr_reg;
        b_sel = bar_reg;
      end
      default: begin
        b_sel = bar_reg;
      end
    endcase
    if (!start_taken) begin
      variant_next = variant_reg;
    end
  end

  // ************************************************************
  // Search sequencer
  // ************************************************************
  // One character read per argument or table state visit: an argument character, then the
  // table character at the same offset. A field that fails is walked to its
  // mark in the skip state and the argument is read again from its right end;
  // this costs memory cycles but keeps no copy of the argument in the block.
  always_comb begin
    state_next = state_reg;
    first_ptr_next = first_ptr_reg;
    bar_next = bar_reg;
    arg_start_next = arg_start_reg;
    arg_ptr_next = arg_ptr_reg;
    tab_ptr_next = tab_ptr_reg;
    mem_addr_next = mem_addr_reg;
    arg_char_next = arg_char_reg;
    arg_wm_next = arg_wm_reg;
    low_next = low_reg;
    equal_next = equal_reg;
    high_next = high_reg;
    done_next = 1'b0;
    cmp_clear = 1'b0;
    cmp_step = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_taken) begin
          first_ptr_next = a_sel;
          bar_next = b_sel;
          arg_start_next = a_sel;
          arg_ptr_next = a_sel;
          tab_ptr_next = b_sel;
          mem_addr_next = a_sel;
          cmp_clear = 1'b1;
          state_next = ST_ARG;
        end
      end
      ST_ARG: begin
        if (mem_ack) begin
          arg_char_next = mem_rdata;
          arg_wm_next = mem_rwm;
          mem_addr_next = tab_ptr_reg;
          state_next = ST_TAB;
        end
      end
      ST_TAB: begin
        if (mem_ack) begin
          cmp_step = 1'b1;
          // Short field wins over a hit on the same character
          if (mem_rwm) begin
            // Field ends no later than the argument: it holds no value
            low_next = 1'b0;
            equal_next = 1'b0;
            high_next = 1'b1;
            first_ptr_next = dec(arg_ptr_reg);
            bar_next = dec(tab_ptr_reg);
            done_next = 1'b1;
            state_next = ST_IDLE;
          end else if (arg_wm_reg) begin
            // Argument exhausted: the whole field argument has been compared
            if (hit) begin
              low_next = (rel_now == table_search_pkg::REL_LT);
              equal_next = (rel_now == table_search_pkg::REL_EQ);
              high_next = (rel_now == table_search_pkg::REL_GT);
              first_ptr_next = dec(arg_ptr_reg);
              bar_next = dec(tab_ptr_reg);
              done_next = 1'b1;
              state_next = ST_IDLE;
            end else begin
              tab_ptr_next = dec(tab_ptr_reg);
              mem_addr_next = dec(tab_ptr_reg);
              cmp_clear = 1'b1;
              state_next = ST_SKIP;
            end
          end else begin
            // Argument goes on: step both pointers one character left
            arg_ptr_next = dec(arg_ptr_reg);
            tab_ptr_next = dec(tab_ptr_reg);
            mem_addr_next = dec(arg_ptr_reg);
            state_next = ST_ARG;
          end
        end
      end
      ST_SKIP: begin
        // Keep walking left until the field's defining mark
        if (mem_ack) begin
          tab_ptr_next = dec(tab_ptr_reg);
          if (mem_rwm) begin
            // Argument is fetched again for each field; no local copy kept
            arg_ptr_next = arg_start_reg;
            mem_addr_next = arg_start_reg;
            state_next = ST_ARG;
          end else begin
            mem_addr_next = dec(tab_ptr_reg);
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      // Indicators and pointers clear so no stale outcome shows before a search
      state_reg <= ST_IDLE;
      variant_reg <= table_search_pkg::VARIANT_RST;
      first_ptr_reg <= table_search_pkg::ADDR_RST;
      bar_reg <= table_search_pkg::ADDR_RST;
      arg_start_reg <= table_search_pkg::ADDR_RST;
      arg_ptr_reg <= table_search_pkg::ADDR_RST;
      tab_ptr_reg <= table_search_pkg::ADDR_RST;
      mem_addr_reg <= table_search_pkg::ADDR_RST;
      arg_char_reg <= table_search_pkg::CHAR_RST;
      arg_wm_reg <= 1'b0;
      low_reg <= 1'b0;
      equal_reg <= 1'b0;
      high_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      variant_reg <= variant_next;
      first_ptr_reg <= first_ptr_next;
      bar_reg <= bar_next;
      arg_start_reg <= arg_start_next;
      arg_ptr_reg <= arg_ptr_next;
      tab_ptr_reg <= tab_ptr_next;
      mem_addr_reg <= mem_addr_next;
      arg_char_reg <= arg_char_next;
      arg_wm_reg <= arg_wm_next;
      low_reg <= low_next;
      equal_reg <= equal_next;
      high_reg <= high_next;
      done_reg <= done_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_comb begin
    busy = (state_reg != ST_IDLE);
    // Request follows state, so reads of one search come with no gap
    mem_req = (state_reg != ST_IDLE);
    mem_addr = mem_addr_reg;
    done = done_reg;
    cmp_low = low_reg;
    cmp_equal = equal_reg;
    cmp_high = high_reg;
    first_operand_pointer = first_ptr_reg;
    second_operand_pointer = bar_reg;
    variant_held = variant_reg;
  end

endmodule

/* table_search_pkg.sv */
// Shared constants and types for the table search sequencer
package table_search_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W = 19;
  localparam int CHAR_W = 6;
  localparam int VAR_W = 6;
  localparam int FMT_W = 2;

  localparam logic [ADDR_W-1:0] ADDR_ONE = 19'h00001;
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [VAR_W-1:0] VARIANT_RST = 6'h00;
  localparam logic [CHAR_W-1:0] CHAR_RST = 6'h00;

  // ************************************************************
  // Instruction formats
  // ************************************************************
  localparam logic [FMT_W-1:0] FMT_A = 2'h0;
  localparam logic [FMT_W-1:0] FMT_B = 2'h1;
  localparam logic [FMT_W-1:0] FMT_C = 2'h2;
  localparam logic [FMT_W-1:0] FMT_D = 2'h3;

  // ************************************************************
  // Relationship codes
  // ************************************************************
  localparam logic [VAR_W-1:0] VAR_LT = 6'h01;
  localparam logic [VAR_W-1:0] VAR_EQ = 6'h02;
  localparam logic [VAR_W-1:0] VAR_LE = 6'h03;
  localparam logic [VAR_W-1:0] VAR_GT = 6'h04;
  localparam logic [VAR_W-1:0] VAR_NE = 6'h05;
  localparam logic [VAR_W-1:0] VAR_GE = 6'h06;

  // Stored argument relative to search argument
  typedef enum logic [1:0] {
    REL_EQ = 2'h0,
    REL_LT = 2'h1,
    REL_GT = 2'h2
  } rel_e;

endpackage

/* char_compare.sv */
// Serial right-to-left magnitude comparator for character fields
`timescale 1ns/1ps
module char_compare (
  input wire logic clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic step,
  input wire logic [table_search_pkg::CHAR_W-1:0] stored,
  input wire logic [table_search_pkg::CHAR_W-1:0] search,
  output table_search_pkg::rel_e rel_now,
  output table_search_pkg::rel_e rel_reg
);

  table_search_pkg::rel_e rel_next;

  // Characters arrive least significant first, so a later difference overrides
  always_comb begin
    if (stored < search) begin
      rel_now = table_search_pkg::REL_LT;
    end else if (stored > search) begin
      rel_now = table_search_pkg::REL_GT;
    end else begin
      rel_now = rel_reg;
    end
    if (clear) begin
      rel_next = table_search_pkg::REL_EQ;
    end else if (step) begin
      rel_next = rel_now;
    end else begin
      rel_next = rel_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rel_reg <= table_search_pkg::REL_EQ;
    end else begin
      rel_reg <= rel_next;
    end
  end

endmodule

/* relation_decode.sv */
// Decodes the relationship code against a comparison result
`timescale 1ns/1ps
module relation_decode (
  input wire logic [table_search_pkg::VAR_W-1:0] variant,
  input table_search_pkg::rel_e rel,
  output logic hit
);

  function automatic logic rel_hit(input logic [table_search_pkg::VAR_W-1:0] v, input table_search_pkg::rel_e r);
    logic lt;
    logic eq;
    logic gt;
    lt = (r == table_search_pkg::REL_LT);
    eq = (r == table_search_pkg::REL_EQ);
    gt = (r == table_search_pkg::REL_GT);
    case (v)
      table_search_pkg::VAR_LT: rel_hit = lt;
      table_search_pkg::VAR_EQ: rel_hit = eq;
      table_search_pkg::VAR_LE: rel_hit = lt | eq;
      table_search_pkg::VAR_GT: rel_hit = gt;
      table_search_pkg::VAR_NE: rel_hit = !eq;
      table_search_pkg::VAR_GE: rel_hit = gt | eq;
      // Undefined codes never match; only a short field ends the search
      default: rel_hit = 1'b0;
    endcase
  endfunction

  always_comb begin
    hit = rel_hit(variant, rel);
  end

endmodule

/* table_search_op_assertions.sv */
// Concurrent checks on the table search sequencer ports
`timescale 1ns/1ps
module table_search_op_assertions (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [table_search_pkg::FMT_W-1:0] format,
  input wire logic [table_search_pkg::ADDR_W-1:0] a_addr,
  input wire logic busy,
  input wire logic done,
  input wire logic mem_req,
  input wire logic [table_search_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic cmp_low,
  input wire logic cmp_equal,
  input wire logic cmp_high,
  input wire logic [table_search_pkg::ADDR_W-1:0] first_operand_pointer
);
  // ************************************************************
  // Handshake and result checks
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence taken;
    start && !busy;
  endsequence
  sequence last_read;
    mem_req && mem_ack;
  endsequence

  req_tracks_busy_a: assert property (mem_req == busy) else $error("mem_req and busy disagree");
  addr_held_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("read address moved before ack");
  done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
  done_cause_a: assert property (done |-> $past(mem_ack && mem_req) && !busy)
    else $error("done without a final read");
  busy_end_a: assert property ($fell(busy) |-> done) else $error("search ended without done");
  arg_first_a: assert property (taken ##0 (format != table_search_pkg::FMT_D)
    |=> busy && mem_addr == $past(a_addr)) else $error("first read not at argument address");
  held_arg_a: assert property (taken ##0 (format == table_search_pkg::FMT_D)
    |=> mem_addr == $past(first_operand_pointer)) else $error("held argument pointer unused");
  ind_hold_a: assert property (!done |-> $stable({cmp_low, cmp_equal, cmp_high}))
    else $error("indicators changed outside done");
  ind_onehot_a: assert property (done |-> $onehot({cmp_low, cmp_equal, cmp_high}))
    else $error("indicators not one-hot at done");
  read_then_done_a: assert property (last_read ##1 !busy |-> done) else $error("read ended without done");
endmodule

/* char_memory_model.sv */
// Behavioural character memory answering the sequencer's reads
`timescale 1ns/1ps
module char_memory_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic mem_req,
  input wire logic [table_search_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [3:0] wait_cycles,
  output logic mem_ack,
  output logic [table_search_pkg::CHAR_W-1:0] mem_rdata,
  output logic mem_rwm
);
  // ************************************************************
  // Storage and answer timing
  // ************************************************************
  logic [6:0] cells [int];
  int cnt;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 6'h00;
    mem_rwm = 1'b0;
    cnt = 0;
  end
  always @(posedge clk) begin
    if (srst || !mem_req || mem_ack || cnt < int'(wait_cycles)) begin
      // Idle data toggles so a stale read never looks valid
      mem_ack <= 1'b0;
      {mem_rwm, mem_rdata} <= ~{mem_rwm, mem_rdata};
      cnt <= (srst || !mem_req || mem_ack) ? 0 : cnt + 1;
    end else begin
      mem_ack <= 1'b1;
      {mem_rwm, mem_rdata} <= cells.exists(int'(mem_addr)) ? cells[int'(mem_addr)] : 7'h00;
    end
  end
endmodule

/* test_table_search_op.sv */
// Self-checking bench for the table search sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module test_table_search_op;
  // ************************************************************
  // Stimulus, scenarios and verdict
  // ************************************************************
  localparam int AW = table_search_pkg::ADDR_W;
  logic clk, srst, start, busy, done, mem_req, mem_ack, mem_rwm, cmp_low, cmp_equal, cmp_high;
  logic [1:0] format;
  logic [AW-1:0] a_addr, b_addr, mem_addr, first_operand_pointer, second_operand_pointer;
  logic [5:0] variant_in, mem_rdata, variant_held;
  logic [3:0] wait_cycles;
  int n_mismatch, n_compared;

  table_search_op dut (.clk(clk), .srst(srst), .start(start), .format(format), .a_addr(a_addr),
    .b_addr(b_addr), .variant_in(variant_in), .busy(busy), .done(done), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_rwm(mem_rwm),
    .cmp_low(cmp_low), .cmp_equal(cmp_equal), .cmp_high(cmp_high),
    .first_operand_pointer(first_operand_pointer), .second_operand_pointer(second_operand_pointer),
    .variant_held(variant_held));
  char_memory_model mem (.clk(clk), .srst(srst), .mem_req(mem_req), .mem_addr(mem_addr),
    .wait_cycles(wait_cycles), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_rwm(mem_rwm));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task put(input int a, input [5:0] d, input wm);
    mem.cells[a] = {wm, d};
  endtask

  // Poke raises start again while busy; that request must be ignored
  task run(input [1:0] f, input [AW-1:0] a, b, input [5:0] v, input [AW-1:0] es, ef, input [2:0] ei,
           input poke);
    int k;
    format = f;
    a_addr = a;
    b_addr = b;
    variant_in = v;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = poke;
    variant_in = 6'h01;
    b_addr = 19'h000D1;
    @(posedge clk);
    #1;
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 5000) begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK(done, 1'b1)
    `CHK(second_operand_pointer, es)
    `CHK(first_operand_pointer, ef)
    `CHK({cmp_low, cmp_equal, cmp_high}, ei)
  endtask

  task check_reset;
    `CHK({busy, done, mem_req, cmp_low, cmp_equal, cmp_high}, 6'h00)
    `CHK({first_operand_pointer, second_operand_pointer, variant_held}, 44'h0)
    $display("reset test done");
  endtask

  // Back to back: each start lands in the done cycle of the one before
  task check_variants;
    logic [AW-1:0] es [1:6];
    logic [2:0] ei [1:6];
    es = '{19'hC9, 19'hCC, 19'hCC, 19'hCF, 19'hCF, 19'hCF};
    ei = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1};
    for (int v = 1; v <= 6; v++) begin
      run(table_search_pkg::FMT_A, 19'h66, 19'hD1, 6'(v), es[v], 19'h64, ei[v], 1'b0);
    end
    `CHK(variant_held, table_search_pkg::VAR_GE)
    $display("variant test done");
  endtask

  task check_held_table;
    run(table_search_pkg::FMT_C, 19'h66, 19'hD1, 6'h02, 19'hCE, 19'h65, 3'h1, 1'b0);
    $display("held table test done");
  endtask

  task check_held_both;
    run(table_search_pkg::FMT_D, 19'h12C, 19'h12C, 6'h02, 19'hCD, 19'h64, 3'h1, 1'b0);
    $display("held operands test done");
  endtask

  task check_held_variant;
    run(table_search_pkg::FMT_B, 19'h66, 19'hCB, 6'h01, 19'hC7, 19'h65, 3'h1, 1'b0);
    `CHK(variant_held, table_search_pkg::VAR_GE)
    $display("held variant test done");
  endtask

  // Unknown code never matches, so only the short field can end it
  task check_short_field;
    wait_cycles = 4'h3;
    run(table_search_pkg::FMT_A, 19'h66, 19'hD1, 6'h07, 19'hC7, 19'h65, 3'h1, 1'b1);
    `CHK(variant_held, 6'h07)
    $display("short field test done");
  endtask

  initial begin
    #(5 * 20000);
    n_mismatch++;
    end_of_test;
  end

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    {srst, start, format, a_addr, b_addr, variant_in} = {1'b1, 1'b0, 2'h0, 19'h0, 19'h0, 6'h00};
    wait_cycles = 4'h0;
    // Word-marked argument and fields of equal length, short terminator
    put(101, 6'h05, 1'b1); put(102, 6'h07, 1'b0); put(200, 6'h01, 1'b1);
    put(201, 6'h3F, 1'b1); put(202, 6'h05, 1'b0); put(203, 6'h02, 1'b0);
    put(204, 6'h3F, 1'b1); put(205, 6'h05, 1'b0); put(206, 6'h07, 1'b0);
    put(207, 6'h3F, 1'b1); put(208, 6'h09, 1'b0); put(209, 6'h09, 1'b0);
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    check_reset;
    check_variants;
    check_held_table;
    check_held_both;
    check_held_variant;
    check_short_field;
    end_of_test;
  end
endmodule

bind table_search_op table_search_op_assertions chk (.clk, .srst, .start, .format, .a_addr, .busy, .done,
  .mem_req, .mem_addr, .mem_ack, .cmp_low, .cmp_equal, .cmp_high, .first_operand_pointer);
